// ==== rtl/link_aspm_status.sv ====
// Per-port active-state link power control and link status outputs.
// Assumes all inputs synchronous to clk; port 0 is the upstream port.
`timescale 1ns/1ps
`default_nettype none
`include "link_pm_defs.svh"

// Overview of operation
// - A port makes ASPM transitions only when its link control enables them, except a downstream port following its partner into L1.
// - Once enabled, hardware enters L0s and L1 on its own with no software step.
// - L0s is entered from L0 only after its conditions hold for the L0s entry time.
// - Upstream L0s needs every live non-D3 downstream port's receive lanes in L0s.
// - Upstream L0s needs no DLLPs pending and no TLP to send or no credits.
// - Downstream L0s needs upstream receive in L0s, no DLLPs, no TLP or credits.
// - L1 is pursued only after its conditions hold for the L1 entry time.
// - With L1 conditions met in L0 or L0s, an L1 request goes to the partner.
// - Only the upstream port requests L1; downstream ports never do.
// - On acknowledge the port enters L1, on refusal it enters L0s.
// - Upstream requests L1 only when every live non-D3 downstream port is in L1.
// - Link-up is high in L0, L0s, L1 or Recovery and low when the link is down.
// - Activity fires on any sent or received TLP except vendor-defined messages.
// - Activity stays high at least 200 ms, restarting on further traffic.
// - Status outputs go out through expander 4, updated at most every 40 ms.
// - Detect, Polling, Config, Disabled, Loopback and Hot-Reset count as link down.
module link_aspm_status #(
    parameter int NPORTS     = 8,
    parameter int EXP_PERIOD = `EXP_PERIOD_CYC,
    parameter int HOLD_PER   = `ACT_HOLD_PERIODS
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Per-port control and state
    input  wire link_pm_pkg::port_in_s   port_in [NPORTS],
    // Partner answer to an upstream L1 request
    input  wire logic                    l1_ack,
    input  wire logic                    l1_nak,
    // Per-port power control
    output link_pm_pkg::port_out_s       port_out [NPORTS],
    // Expander 4 image
    output logic [NPORTS-1:0]            port_link_up_out,
    output logic [NPORTS-1:0]            port_activity_out,
    output logic                         exp_update
);

    function automatic logic link_down(input link_pm_pkg::ltssm_e s);
        link_down = !(s == link_pm_pkg::LT_L0 || s == link_pm_pkg::LT_L0S ||
                      s == link_pm_pkg::LT_L1 ||
                      s == link_pm_pkg::LT_RECOVERY);
    endfunction : link_down

    function automatic logic tx_idle(input link_pm_pkg::port_in_s p);
        tx_idle = !p.dllp_pending &&
                  (!p.tlp_pending || !p.credits_avail);
    endfunction : tx_idle

    logic [NPORTS-1:0] dn_live;
    logic              all_dn_rx_l0s;
    logic              all_dn_l1;
    logic [NPORTS-1:0] l0s_cond;
    logic [NPORTS-1:0] l1_cond;
    logic [NPORTS-1:0] l0s_done;
    logic [NPORTS-1:0] l1_done;

    link_pm_pkg::pm_state_e st_q [NPORTS];
    link_pm_pkg::pm_state_e st_d [NPORTS];

    always_comb
    begin
        all_dn_rx_l0s = 1'b1;
        all_dn_l1     = 1'b1;
        for (int i = 0; i < NPORTS; i++)
        begin
            dn_live[i] = (i != `UP_PORT) && !port_in[i].in_d3 &&
                         !link_down(port_in[i].ltssm);
            if (dn_live[i] && !port_in[i].rx_in_l0s)
                all_dn_rx_l0s = 1'b0;
            if (dn_live[i] && st_q[i] != link_pm_pkg::PM_L1)
                all_dn_l1 = 1'b0;
        end
        for (int i = 0; i < NPORTS; i++)
        begin
            if (i == `UP_PORT)
            begin
                l0s_cond[i] = port_in[i].aspm_ctl[`ASPM_L0S_BIT] &&
                              all_dn_rx_l0s && tx_idle(port_in[i]);
                l1_cond[i]  = port_in[i].aspm_ctl[`ASPM_L1_BIT] &&
                              all_dn_l1 && tx_idle(port_in[i]);
            end
            else
            begin
                l0s_cond[i] = port_in[i].aspm_ctl[`ASPM_L0S_BIT] &&
                              port_in[`UP_PORT].rx_in_l0s &&
                              tx_idle(port_in[i]);
                l1_cond[i]  = 1'b0;
            end
            if (link_down(port_in[i].ltssm))
            begin
                l0s_cond[i] = 1'b0;
                l1_cond[i]  = 1'b0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPORTS; g++)
        begin : g_tmr
            link_entry_timer #(.W(8), .SCALE_W(8)) u_l0s (
                .clk   (clk),
                .reset (reset),
                .cond  (l0s_cond[g]),
                .limit (port_in[g].l0s_entry_timer),
                .done  (l0s_done[g])
            );
            link_entry_timer #(.W(8), .SCALE_W(8)) u_l1 (
                .clk   (clk),
                .reset (reset),
                .cond  (l1_cond[g]),
                .limit (port_in[g].l1_entry_timer),
                .done  (l1_done[g])
            );
        end
    endgenerate

    // Per-port transmit power state
    always_comb
    begin
        for (int i = 0; i < NPORTS; i++)
        begin
            st_d[i] = st_q[i];
            if (link_down(port_in[i].ltssm) || port_in[i].aspm_ctl == 2'h0)
                st_d[i] = link_pm_pkg::PM_L0;
            else
            begin
                unique case (st_q[i])
                    link_pm_pkg::PM_L0:
                        if (l1_done[i])
                            st_d[i] = link_pm_pkg::PM_L1_REQ;
                        else if (l0s_done[i])
                            st_d[i] = link_pm_pkg::PM_L0S;
                    link_pm_pkg::PM_L0S:
                        if (l1_done[i])
                            st_d[i] = link_pm_pkg::PM_L1_REQ;
                        else if (!l0s_cond[i])
                            st_d[i] = link_pm_pkg::PM_L0;
                    link_pm_pkg::PM_L1_REQ:
                        if (l1_ack)
                            st_d[i] = link_pm_pkg::PM_L1;
                        else if (l1_nak)
                            st_d[i] = link_pm_pkg::PM_L0S;
                    link_pm_pkg::PM_L1:
                        if (!l1_cond[i])
                            st_d[i] = link_pm_pkg::PM_L0;
                    default:
                        st_d[i] = link_pm_pkg::PM_L0;
                endcase
            end
            // Downstream ports follow their partner's L1 entry
            if (i != `UP_PORT && port_in[i].ltssm == link_pm_pkg::LT_L1)
                st_d[i] = link_pm_pkg::PM_L1;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < NPORTS; i++)
                st_q[i] <= link_pm_pkg::PM_L0;
        end
        else
        begin
            for (int i = 0; i < NPORTS; i++)
                st_q[i] <= st_d[i];
        end
    end

    // Watch flag: a downstream port must never reach the request state
    logic dn_req_any;

    always_comb
    begin
        dn_req_any = 1'b0;
        for (int i = 0; i < NPORTS; i++)
        begin
            port_out[i].pm_state   = st_q[i];
            if (i != `UP_PORT && st_q[i] == link_pm_pkg::PM_L1_REQ)
                dn_req_any = 1'b1;
            port_out[i].l0s_enter  = (st_q[i] == link_pm_pkg::PM_L0S);
            port_out[i].l1_request = (i == `UP_PORT) &&
                                     (st_q[i] == link_pm_pkg::PM_L1_REQ);
        end
    end

    // Expander update divider and activity hold
    logic [`EXP_CNT_W-1:0]  div_q;
    logic [`EXP_CNT_W-1:0]  div_d;
    logic                   tick;
    logic [NPORTS-1:0]      hit_q;
    logic [NPORTS-1:0]      hit_d;
    logic [`ACT_CNT_W-1:0]  hold_q [NPORTS];
    logic [`ACT_CNT_W-1:0]  hold_d [NPORTS];
    logic [NPORTS-1:0]      up_d;
    logic [NPORTS-1:0]      act_d;

    assign tick = (div_q == `EXP_CNT_W'(EXP_PERIOD - 1));

    always_comb
    begin
        div_d = tick ? '0 : div_q + 1'b1;
        up_d  = port_link_up_out;
        act_d = port_activity_out;
        for (int i = 0; i < NPORTS; i++)
        begin
            hit_d[i]  = hit_q[i] ||
                        (port_in[i].tlp_seen && !port_in[i].tlp_is_vdm);
            hold_d[i] = hold_q[i];
            if (tick)
            begin
                up_d[i]  = !link_down(port_in[i].ltssm);
                // Traffic since the last update, this cycle included
                if (hit_d[i])
                    hold_d[i] = `ACT_CNT_W'(HOLD_PER);
                else if (hold_q[i] != '0)
                    hold_d[i] = hold_q[i] - 1'b1;
                act_d[i] = (hold_d[i] != '0);
                hit_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            div_q             <= '0;
            hit_q             <= '0;
            port_link_up_out  <= '0;
            port_activity_out <= '0;
            exp_update        <= 1'b0;
            for (int i = 0; i < NPORTS; i++)
                hold_q[i] <= '0;
        end
        else
        begin
            div_q             <= div_d;
            hit_q             <= hit_d;
            port_link_up_out  <= up_d;
            port_activity_out <= act_d;
            exp_update        <= tick;
            for (int i = 0; i < NPORTS; i++)
                hold_q[i] <= hold_d[i];
        end
    end

    a_dn_no_l1req: assert property (
        @(posedge clk) disable iff (reset) !dn_req_any)
        else $error("Downstream port in L1 request state");
    a_l1_ack_enter: assert property (
        @(posedge clk) disable iff (reset)
        (st_q[`UP_PORT] == link_pm_pkg::PM_L1_REQ && l1_ack &&
         !link_down(port_in[`UP_PORT].ltssm) &&
         port_in[`UP_PORT].aspm_ctl != 2'h0)
        |=> st_q[`UP_PORT] == link_pm_pkg::PM_L1)
        else $error("L1 not entered on ack");
    a_aspm_off_l0: assert property (
        @(posedge clk) disable iff (reset)
        (port_in[`UP_PORT].aspm_ctl == 2'h0) |=>
        (st_q[`UP_PORT] == link_pm_pkg::PM_L0))
        else $error("ASPM transition while disabled");
    a_l0s_timed: assert property (
        @(posedge clk) disable iff (reset)
        (st_q[`UP_PORT] == link_pm_pkg::PM_L0 ##1
         st_q[`UP_PORT] == link_pm_pkg::PM_L0S)
        |-> $past(l0s_done[`UP_PORT]))
        else $error("L0s entered before its entry time");
    a_l1req_timed: assert property (
        @(posedge clk) disable iff (reset)
        (st_q[`UP_PORT] != link_pm_pkg::PM_L1_REQ ##1
         st_q[`UP_PORT] == link_pm_pkg::PM_L1_REQ)
        |-> $past(l1_done[`UP_PORT]))
        else $error("L1 requested before its entry time");
    a_upd_spacing: assert property (
        @(posedge clk) disable iff (reset)
        exp_update |=> !exp_update)
        else $error("Expander updated twice in a row");
    a_act_only_tick: assert property (
        @(posedge clk) disable iff (reset)
        $changed(port_activity_out) |-> exp_update)
        else $error("Activity changed off update");
    a_act_load: assert property (
        @(posedge clk) disable iff (reset)
        (tick && (hit_q[NPORTS-1] || (port_in[NPORTS-1].tlp_seen &&
                  !port_in[NPORTS-1].tlp_is_vdm)))
        |=> port_activity_out[NPORTS-1])
        else $error("Activity not raised after traffic");
    a_up_follows: assert property (
        @(posedge clk) disable iff (reset)
        tick |=> port_link_up_out[`UP_PORT] ==
                 !link_down($past(port_in[`UP_PORT].ltssm)))
        else $error("Link-up wrong after update");

    c_l0s: cover property (@(posedge clk) port_out[`UP_PORT].l0s_enter);
    c_l1: cover property (@(posedge clk)
        st_q[`UP_PORT] == link_pm_pkg::PM_L1);
    c_nak: cover property (@(posedge clk)
        st_q[`UP_PORT] == link_pm_pkg::PM_L1_REQ && l1_nak);
    c_act: cover property (@(posedge clk) port_activity_out[`UP_PORT]);

endmodule : link_aspm_status

`default_nettype wire

// ==== common/link_pm_defs.svh ====
// Constants for the per-port link power management and status block.
// Assumes a 125 MHz core clock; included by its bare name.
`ifndef LINK_PM_DEFS_SVH
`define LINK_PM_DEFS_SVH

`define CLK_PERIOD_NS      8
`define ACT_HOLD_MS        200
`define EXP_PERIOD_MS      40
`define NS_PER_MS          1000000
`define EXP_PERIOD_CYC     ((`EXP_PERIOD_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define ACT_HOLD_PERIODS   ((`ACT_HOLD_MS + `EXP_PERIOD_MS - 1) / `EXP_PERIOD_MS)
`define ASPM_L0S_BIT       0
`define ASPM_L1_BIT        1
`define UP_PORT            0
`define ACT_CNT_W          3
`define EXP_CNT_W          23

`endif

// ==== common/link_pm_pkg.sv ====
// Types shared by the link power management block.
// Assumes link_pm_defs.svh is included by users of the numbers.
package link_pm_pkg;

    // LTSSM view reported by each port's physical layer
    typedef enum logic [3:0] {
        LT_DETECT   = 4'h0,
        LT_POLLING  = 4'h1,
        LT_CONFIG   = 4'h2,
        LT_DISABLED = 4'h3,
        LT_LOOPBACK = 4'h4,
        LT_HOTRESET = 4'h5,
        LT_L0       = 4'h6,
        LT_L0S      = 4'h7,
        LT_L1       = 4'h8,
        LT_RECOVERY = 4'h9,
        LT_L2L3     = 4'ha
    } ltssm_e;

    // Transmit-side power state per port, Gray along the usual path
    typedef enum logic [2:0] {
        PM_L0     = 3'b000,
        PM_L0S    = 3'b001,
        PM_L1_REQ = 3'b011,
        PM_L1     = 3'b010
    } pm_state_e;

    // Per-port inputs
    typedef struct packed {
        logic [1:0] aspm_ctl;
        logic [7:0] l0s_entry_timer;
        logic [7:0] l1_entry_timer;
        ltssm_e     ltssm;
        logic       in_d3;
        logic       rx_in_l0s;
        logic       tlp_pending;
        logic       credits_avail;
        logic       dllp_pending;
        logic       tlp_seen;
        logic       tlp_is_vdm;
    } port_in_s;

    // Per-port outputs
    typedef struct packed {
        logic      l0s_enter;
        logic      l1_request;
        pm_state_e pm_state;
    } port_out_s;

endpackage : link_pm_pkg

// ==== rtl/link_entry_timer.sv ====
// Entry timer: counts while its condition holds, restarts when it drops.
// Assumes one tick per core clock scaled by the programmed value.
`timescale 1ns/1ps
`default_nettype none

module link_entry_timer #(
    parameter int W = 8,
    parameter int SCALE_W = 8
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            reset,
    // Condition and limit
    input  wire logic            cond,
    input  wire logic [W-1:0]    limit,
    // Elapsed
    output logic                 done
);
    logic [W+SCALE_W-1:0] cnt_q;
    logic [W+SCALE_W-1:0] cnt_d;
    logic [W+SCALE_W-1:0] lim_full;

    assign lim_full = {limit, {SCALE_W{1'b0}}};

    always_comb
    begin
        cnt_d = cnt_q;
        if (!cond)
            cnt_d = '0;
        else if (cnt_q < lim_full)
            cnt_d = cnt_q + 1'b1;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    assign done = cond && (cnt_q >= lim_full);

endmodule : link_entry_timer

`default_nettype wire

// ==== tb/link_partner_model.sv ====
// Far-end stand-in for the upstream link: answers each L1 request.
// Assumes the bench sets ack_mode and delay before the request rises.
`timescale 1ns/1ps
`default_nettype none

module link_partner_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Request and chosen answer
    input  wire logic       l1_req,
    input  wire logic       ack_mode,
    input  wire logic [2:0] delay,
    // Answer pulses
    output var  logic       l1_ack,
    output var  logic       l1_nak
);
    int cnt;

    // One pulse per request, after the chosen wait
    always @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            cnt    <= 0;
            l1_ack <= 1'b0;
            l1_nak <= 1'b0;
        end
        else
        begin
            l1_ack <= 1'b0;
            l1_nak <= 1'b0;
            if (!l1_req)
                cnt <= 0;
            else if (cnt == int'(delay))
            begin
                l1_ack <= ack_mode;
                l1_nak <= !ack_mode;
                cnt    <= cnt + 1;
            end
            else if (cnt < int'(delay))
                cnt <= cnt + 1;
        end
    end
endmodule : link_partner_model
`default_nettype wire

// ==== tb/tb.sv ====
// Bench for the link power and status block, two ports, port 0 upstream.
// Assumes a short expander period; pm and status checked from queues.
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int NP = 2;
    localparam int EXP = 20;
    logic                   clk;
    logic                   reset;
    link_pm_pkg::port_in_s  pin [NP];
    link_pm_pkg::port_out_s pout [NP];
    link_pm_pkg::ltssm_e    lt;
    logic [NP-1:0]          up;
    logic [NP-1:0]          act;
    logic                   tick;
    logic                   ack;
    logic                   nak;
    logic                   ack_mode;
    logic [2:0]             dly;
    logic [7:0]             lim0;
    logic [7:0]             lim1;
    logic [2:0]             last [NP];
    logic [2:0]             exp_pm [NP][$];
    logic [3:0]             exp_st [$];
    int                     n_errors;
    int                     tests_run;
    int                     since;

    link_aspm_status #(.NPORTS(NP), .EXP_PERIOD(EXP), .HOLD_PER(5)) DUT (
        .clk(clk), .reset(reset), .port_in(pin), .l1_ack(ack),
        .l1_nak(nak), .port_out(pout), .port_link_up_out(up),
        .port_activity_out(act), .exp_update(tick));

    link_partner_model partner (.clk(clk), .reset(reset),
        .l1_req(pout[0].l1_request), .ack_mode(ack_mode), .delay(dly),
        .l1_ack(ack), .l1_nak(nak));

    task automatic tally(input logic ok, input logic [31:0] g,
                         input logic [31:0] e);
        tests_run++;
        if (!ok)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : tally

    task automatic cmp_pm(input logic [2:0] g, input logic [2:0] e);
        tally(g === e, 32'(g), 32'(e));
    endtask : cmp_pm

    task automatic cmp_st(input logic [3:0] g, input logic [3:0] e);
        tally(g === e, 32'(g), 32'(e));
    endtask : cmp_st

    task automatic cmp_cnt(input int g, input int lo, input int hi);
        tally(g >= lo && g <= hi, 32'(g), 32'(lo));
    endtask : cmp_cnt

    task automatic final_report;
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic step;
        @(posedge clk);
    endtask : step

    task automatic ex(input int p, input logic [2:0] st);
        exp_pm[p].push_back(st);
    endtask : ex

    // Returns on the edge that follows a settled update pulse
    task automatic wait_tick;
        do
        begin
            @(posedge clk);
            #1;
        end
        while (tick !== 1'b1);
        @(posedge clk);
    endtask : wait_tick

    // Waits for a state; lo >= 0 also checks the entry time
    task automatic wait_pm(input int p, input logic [2:0] st, input int lo);
        int n;
        n = 0;
        while (pout[p].pm_state !== st && n < 3000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (lo >= 0)
            cmp_cnt(n, lo, lo + 3);
        else
            cmp_cnt(n, 0, 2999);
    endtask : wait_pm

    function automatic logic is_up(input link_pm_pkg::ltssm_e s);
        return s inside {link_pm_pkg::LT_L0, link_pm_pkg::LT_L0S,
                         link_pm_pkg::LT_L1, link_pm_pkg::LT_RECOVERY};
    endfunction : is_up

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Watches state changes and expander ticks against the notes
    always @(posedge clk)
    begin
        #1;
        for (int p = 0; p < NP; p++)
            if (!reset && pout[p].pm_state !== last[p])
            begin
                cmp_pm(pout[p].pm_state, exp_pm[p].size() ?
                       exp_pm[p].pop_front() : 3'bxxx);
                last[p] = pout[p].pm_state;
            end
        if (!reset)
            cmp_pm({2'b00, pout[1].l1_request}, 3'h0);
        if (!reset && tick === 1'b1)
        begin
            if (since > 0)
                cmp_cnt(since, EXP, EXP);
            since = 0;
            if (exp_st.size() > 0)
                cmp_st({up, act}, exp_st.pop_front());
        end
        if (since >= 0)
            since++;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        final_report();
    end

    initial
    begin
        void'($urandom(32'hd731ab4c));
        lim0 = 8'(1 + $urandom % 2);
        lim1 = lim0 + 8'h01;
        n_errors = 0;
        tests_run = 0;
        since = -1;
        ack_mode = 1'b1;
        dly = 3'(1 + $urandom % 4);
        reset = 1'b1;
        foreach (pin[p])
        begin
            pin[p] = '0;
            pin[p].ltssm = link_pm_pkg::LT_L0;
            pin[p].credits_avail = 1'b1;
            pin[p].l0s_entry_timer = lim0;
            pin[p].l1_entry_timer = lim1;
            last[p] = link_pm_pkg::PM_L0;
        end
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        step();
        pin[1].rx_in_l0s <= 1'b1;
        repeat (700) @(posedge clk);
        #1;
        cmp_pm(pout[0].pm_state, link_pm_pkg::PM_L0);
        ex(0, link_pm_pkg::PM_L0S);
        step();
        pin[0].aspm_ctl <= 2'h1;
        repeat (100) @(posedge clk);
        pin[0].dllp_pending <= 1'b1;
        step();
        pin[0].dllp_pending <= 1'b0;
        wait_pm(0, link_pm_pkg::PM_L0S, 256 * lim0);
        ex(0, link_pm_pkg::PM_L0);
        step();
        pin[1].rx_in_l0s <= 1'b0;
        wait_pm(0, link_pm_pkg::PM_L0, -1);
        ex(0, link_pm_pkg::PM_L0S);
        step();
        pin[1].in_d3 <= 1'b1;
        wait_pm(0, link_pm_pkg::PM_L0S, 256 * lim0);
        step();
        pin[1].in_d3 <= 1'b0;
        pin[1].ltssm <= link_pm_pkg::LT_DETECT;
        repeat (20) @(posedge clk);
        ex(0, link_pm_pkg::PM_L0);
        pin[1].ltssm <= link_pm_pkg::LT_L0;
        wait_pm(0, link_pm_pkg::PM_L0, -1);
        ex(0, link_pm_pkg::PM_L0S);
        step();
        pin[1].rx_in_l0s <= 1'b1;
        pin[0].tlp_pending <= 1'b1;
        pin[0].credits_avail <= 1'b0;
        wait_pm(0, link_pm_pkg::PM_L0S, 256 * lim0);
        ex(0, link_pm_pkg::PM_L0);
        step();
        pin[0].credits_avail <= 1'b1;
        wait_pm(0, link_pm_pkg::PM_L0, -1);
        step();
        pin[0].tlp_pending <= 1'b0;
        pin[0].aspm_ctl <= 2'h0;
        pin[1].aspm_ctl <= 2'h1;
        repeat (600) @(posedge clk);
        ex(1, link_pm_pkg::PM_L0S);
        pin[0].rx_in_l0s <= 1'b1;
        wait_pm(1, link_pm_pkg::PM_L0S, 256 * lim0);
        ex(1, link_pm_pkg::PM_L0);
        step();
        pin[1].aspm_ctl <= 2'h0;
        pin[0].rx_in_l0s <= 1'b0;
        wait_pm(1, link_pm_pkg::PM_L0, -1);
        ex(0, link_pm_pkg::PM_L0S);
        step();
        pin[0].aspm_ctl <= 2'h3;
        wait_pm(0, link_pm_pkg::PM_L0S, -1);
        repeat (600) @(posedge clk);
        ex(0, link_pm_pkg::PM_L1_REQ);
        ex(0, link_pm_pkg::PM_L1);
        ex(1, link_pm_pkg::PM_L1);
        pin[1].ltssm <= link_pm_pkg::LT_L1;
        wait_pm(0, link_pm_pkg::PM_L1_REQ, 256 * lim1);
        wait_pm(0, link_pm_pkg::PM_L1, -1);
        ex(0, link_pm_pkg::PM_L0);
        step();
        pin[0].tlp_pending <= 1'b1;
        wait_pm(0, link_pm_pkg::PM_L0, -1);
        ex(0, link_pm_pkg::PM_L0S);
        ex(0, link_pm_pkg::PM_L1_REQ);
        ex(0, link_pm_pkg::PM_L0S);
        ex(0, link_pm_pkg::PM_L0);
        step();
        pin[0].tlp_pending <= 1'b0;
        ack_mode <= 1'b0;
        dly <= 3'(1 + $urandom % 4);
        wait_pm(0, link_pm_pkg::PM_L1_REQ, -1);
        wait_pm(0, link_pm_pkg::PM_L0S, -1);
        ex(1, link_pm_pkg::PM_L0);
        pin[0].aspm_ctl <= 2'h0;
        pin[1].ltssm <= link_pm_pkg::LT_L0;
        wait_pm(0, link_pm_pkg::PM_L0, -1);
        for (int v = 0; v <= 10; v++)
        begin
            step();
            lt = link_pm_pkg::ltssm_e'(v);
            // Downstream state follows its partner into and out of L1
            if (lt == link_pm_pkg::LT_L1)
                ex(1, link_pm_pkg::PM_L1);
            if (lt == link_pm_pkg::LT_RECOVERY)
                ex(1, link_pm_pkg::PM_L0);
            pin[1].ltssm <= lt;
            wait_tick();
            exp_st.push_back({is_up(lt), 1'b1, 2'b00});
            wait_tick();
        end
        pin[1].ltssm <= link_pm_pkg::LT_L0;
        wait_tick();
        pin[1].tlp_seen <= 1'b1;
        pin[1].tlp_is_vdm <= 1'b1;
        step();
        pin[1].tlp_seen <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            wait_tick();
            exp_st.push_back(4'hc);
        end
        wait_tick();
        pin[1].tlp_seen <= 1'b1;
        pin[1].tlp_is_vdm <= 1'b0;
        step();
        pin[1].tlp_seen <= 1'b0;
        wait_tick();
        for (int k = 0; k < 5; k++)
        begin
            exp_st.push_back({2'b11, k < 4, 1'b0});
            wait_tick();
        end
        step();
        final_report();
    end
endmodule : tb
`default_nettype wire
